/* common/swdt_consts.vh */
// constants for the system watchdog timer
`ifndef SWDT_CONSTS_VH
`define SWDT_CONSTS_VH
`define SWDT_TMO_W        8
`define SWDT_TMO_RST      8'h00
`define SWDT_CLK_HZ       25000000
`define SWDT_UNIT_SEC_MS  1000
`define SWDT_UNIT_MIN_MS  60000
`define SWDT_UNIT_SEC_CYC (`SWDT_CLK_HZ / 1000 * `SWDT_UNIT_SEC_MS)
`define SWDT_UNIT_MIN_CYC (`SWDT_CLK_HZ / 1000 * `SWDT_UNIT_MIN_MS)
`define SWDT_PRE_W        32
`define SWDT_ACT_RESET    1'b0
`define SWDT_ACT_NMI      1'b1
`define SWDT_RST_PULSE    16
`endif

/* dv/swdt_host.sv */
// host software model: reloads the time-out on a fixed period
`default_nettype none
module swdt_host #(parameter int PER = 25) (
    input  wire logic       clk_i,
    input  wire logic       en_i,
    output var  logic       load_o = 1'b0,
    output wire logic [7:0] tmo_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    // three units of count, period well inside it
    assign tmo_o = 8'h03;
    always @(posedge clk_i)
    begin
        n <= en_i ? (n + 1) % PER : 0;
        load_o <= #1 en_i && n == 0;
    end
endmodule
`default_nettype wire

/* dv/swdt_props.sv */
// assertions on the watchdog top ports
`include "swdt_consts.vh"
`default_nettype none
module swdt_props (
    input wire logic       clk_i, sys_rst_i, ce_i, load_i, unit_min_i, act_nmi_i,
    input wire logic [7:0] tmo_i, count_o,
    input wire logic       armed_o, cold_rst_o, nmi_o, expired_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [7:0] fire_left;
    wire logic  in_fire;
    // fire phase tracker: loads are refused while it runs
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
            fire_left <= 8'h00;
        else if (ce_i && expired_o)
            fire_left <= 8'(`SWDT_RST_PULSE - 1);
        else if (ce_i && fire_left != 8'h00)
            fire_left <= fire_left - 8'h01;
    end
    assign in_fire = expired_o || fire_left != 8'h00;
    property p_arm; ce_i && load_i && !in_fire
        |=> count_o == $past(tmo_i) && armed_o == (count_o != 8'h00); endproperty
    a_arm: assert property (p_arm) else $error("load not taken");
    property p_off; ce_i && load_i && tmo_i == 8'h00 && !in_fire
        |=> !armed_o && !expired_o ##1 !expired_o; endproperty
    a_off: assert property (p_off) else $error("zero load left it armed");
    property p_exp; expired_o |-> $past(armed_o) && $past(count_o) == 8'h01; endproperty
    a_exp: assert property (p_exp) else $error("expiry without count end");
    property p_act; expired_o |-> cold_rst_o != nmi_o; endproperty
    a_act: assert property (p_act) else $error("not exactly one action");
    property p_pls; ($rose(cold_rst_o) || nmi_o) |-> expired_o ##1 !nmi_o; endproperty
    a_pls: assert property (p_pls) else $error("action outside expiry");
    property p_dec; $changed(count_o) && !$past(load_i && ce_i)
        |-> count_o == $past(count_o) - 8'h01; endproperty
    a_dec: assert property (p_dec) else $error("count step wrong");
    property p_len; cold_rst_o |-> in_fire; endproperty
    a_len: assert property (p_len) else $error("reset outside fire phase");
endmodule
bind swdt_top swdt_props i_swdt_props (.*);
`default_nettype wire

/* dv/swdt_top_test.sv */
// self-checking bench for the watchdog top
`include "swdt_consts.vh"
`default_nettype none
module swdt_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, sys_rst_i = 1, load_i = 0, unit_min_i = 0, act_nmi_i = 0, host_en = 0;
    logic ce_i = 1;
    logic [7:0] tmo_i = 8'h00;
    wire logic armed_o, cold_rst_o, nmi_o, expired_o, host_ld;
    wire logic [7:0] count_o, host_tmo;
    int num_errors = 0, tests_run = 0, cyc = 0, k;
    swdt_top #(.SEC_CYC(10), .MIN_CYC(20)) i_swdt_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .ce_i(ce_i), .load_i(load_i | host_ld), .tmo_i(host_en ? host_tmo : tmo_i),
        .unit_min_i(unit_min_i), .act_nmi_i(act_nmi_i), .armed_o(armed_o), .count_o(count_o),
        .cold_rst_o(cold_rst_o), .nmi_o(nmi_o), .expired_o(expired_o));
    swdt_host i_swdt_host (.clk_i(clk_i), .en_i(host_en), .load_o(host_ld), .tmo_o(host_tmo));
    // clock and cycle ceiling
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            num_errors++;
            results();
        end
    end
    task results();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task check(input string what, input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task ld(input logic [7:0] v, input logic m, n);
        @(posedge clk_i);
        #1 load_i = 1;
        {tmo_i, unit_min_i, act_nmi_i} = {v, m, n};
        @(posedge clk_i);
        #1 load_i = 0;
    endtask
    task t_fire(input logic [7:0] v, input logic m, n);
        ld(8'hC8, 0, 0);
        ld(v, m, n);
        check("count", count_o, v);
        for (k = 0; k < 400 && expired_o !== 1'b1; k++)
            @(posedge clk_i) #1;
        check("time", k >= v * (m ? 20 : 10) - 1 && k <= v * (m ? 20 : 10) + 1, 1);
        check("reset", cold_rst_o, !n);
        check("nmi", nmi_o, n);
        check("count end", count_o, 8'h00);
        @(posedge clk_i) #1;
        check("expired len", expired_o, 0);
        check("nmi len", nmi_o, 0);
        repeat (`SWDT_RST_PULSE - 2) @(posedge clk_i);
        #1 check("hold", cold_rst_o, !n);
        @(posedge clk_i) #1;
        check("release", cold_rst_o, 0);
        repeat (4) @(posedge clk_i);
        $display("fire test done");
    endtask
    task t_zero();
        logic seen;
        ld(8'h05, 0, 0);
        ld(8'h00, 0, 1);
        check("armed", armed_o, 0);
        seen = 0;
        repeat (120)
        begin
            @(posedge clk_i) #1;
            seen = seen | armed_o | cold_rst_o | nmi_o | expired_o;
        end
        check("quiet", seen, 0);
        $display("zero test done");
    endtask
    task t_hold();
        logic seen;
        ld(8'h02, 0, 0);
        repeat (5) @(posedge clk_i);
        #1 ce_i = 0;
        seen = 0;
        repeat (40)
        begin
            @(posedge clk_i) #1;
            seen = seen | expired_o | cold_rst_o;
        end
        check("frozen", count_o, 8'h02);
        check("no fire", {seen, armed_o}, 2'b01);
        ce_i = 1;
        ld(8'h00, 0, 0);
        check("hold off", armed_o, 0);
        $display("hold test done");
    endtask
    task t_refresh();
        logic seen;
        ld(8'h03, 0, 0);
        host_en = 1;
        seen = 0;
        repeat (200)
        begin
            @(posedge clk_i) #1;
            seen = seen | cold_rst_o | nmi_o | expired_o;
        end
        check("alive", {armed_o, seen}, 2'b10);
        host_en = 0;
        ld(8'h00, 0, 0);
        check("off", armed_o, 0);
        $display("refresh test done");
    endtask
    // reset, then the scenarios
    initial
    begin
        repeat (8) @(posedge clk_i);
        #1 sys_rst_i = 0;
        t_fire(8'h03, 0, 0);
        t_fire(8'h01, 0, 1);
        t_fire(8'h02, 1, 0);
        t_fire(8'h02, 1, 1);
        t_zero();
        t_refresh();
        t_hold();
        results();
    end
endmodule
`default_nettype wire

/* rtl/swdt_tick.v */
// time-base prescaler producing one tick per count unit
`default_nettype none
module swdt_tick #(
    parameter PRE_W   = 32,
    parameter SEC_CYC = 25000000,
    parameter MIN_CYC = 1500000000
) (
    input  wire             clk_i,
    input  wire             sys_rst_i,
    input  wire             ce_i,
    input  wire             restart_i,
    input  wire             unit_min_i,
    output reg              tick_o
);
    reg  [PRE_W-1:0] cnt;
    wire [PRE_W-1:0] lim;

    // terminal counts, cut to the prescaler width
    localparam integer SEC_LIM = SEC_CYC - 1;
    localparam integer MIN_LIM = MIN_CYC - 1;

    // terminal count from the unit selection
    assign lim = unit_min_i ? MIN_LIM[PRE_W-1:0] : SEC_LIM[PRE_W-1:0];

    // free count, cleared on restart
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cnt    <= {PRE_W{1'b0}};
            tick_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (restart_i || cnt >= lim)
            begin
                cnt    <= {PRE_W{1'b0}};
                tick_o <= ~restart_i;
            end
            else
            begin
                cnt    <= cnt + 1'b1;
                tick_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/swdt_top.v */
// system watchdog timer: load, countdown and expiry action
// Functional notes
// - nonzero load outside the fire phase arms and starts countdown
// - counter reaching zero triggers expiry action
// - zero load disables and suppresses expiry
// - expiry gives cold reset or nmi
// - stored unit selection sets count step
`include "swdt_consts.vh"
`default_nettype none
module swdt_top #(
    parameter TMO_W     = `SWDT_TMO_W,
    parameter PRE_W     = `SWDT_PRE_W,
    parameter SEC_CYC   = `SWDT_UNIT_SEC_CYC,
    parameter MIN_CYC   = `SWDT_UNIT_MIN_CYC,
    parameter RST_PULSE = `SWDT_RST_PULSE
) (
    input  wire             clk_i,
    input  wire             sys_rst_i,
    input  wire             ce_i,
    input  wire             load_i,
    input  wire [TMO_W-1:0] tmo_i,
    input  wire             unit_min_i,
    input  wire             act_nmi_i,
    output reg              armed_o,
    output reg  [TMO_W-1:0] count_o,
    output reg              cold_rst_o,
    output reg              nmi_o,
    output reg              expired_o
);
    localparam ST_IDLE = 2'b00;
    localparam ST_RUN  = 2'b01;
    localparam ST_FIRE = 2'b10;

    reg  [1:0]       state;
    reg  [1:0]       next_state;
    reg              unit_min;
    reg              act_nmi;
    reg  [7:0]       pulse_cnt;
    wire             tick;
    wire             restart;
    wire             take;
    wire             step;
    wire             fire_next;
    wire             fire_start;

    // a load is taken anywhere but in the fire phase; loads
    // arriving while the expiry action runs are dropped
    assign take    = load_i && (state != ST_FIRE);

    // a taken load also restarts the time base, so a refresh
    // always buys a full count unit before the next step
    assign restart = take;

    // one count step per time-base tick while running
    assign step    = (state == ST_RUN) && tick && (count_o != {TMO_W{1'b0}});

    // fire phase entered or held on the coming edge
    assign fire_next  = (next_state == ST_FIRE);

    // last run cycle, fire phase entered on the coming edge
    assign fire_start = (state == ST_RUN) && fire_next;

    swdt_tick #(
        .PRE_W   (PRE_W),
        .SEC_CYC (SEC_CYC),
        .MIN_CYC (MIN_CYC)
    ) i_swdt_tick (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .ce_i       (ce_i),
        .restart_i  (restart),
        .unit_min_i (unit_min),
        .tick_o     (tick)
    );

    // next state
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (load_i && tmo_i != {TMO_W{1'b0}})
                    next_state = ST_RUN;
            end
            ST_RUN:
            begin
                if (load_i)
                    next_state = (tmo_i == {TMO_W{1'b0}}) ? ST_IDLE : ST_RUN;
                else if (tick && count_o == {{(TMO_W-1){1'b0}}, 1'b1})
                    next_state = ST_FIRE;
            end
            ST_FIRE:
            begin
                if (pulse_cnt == RST_PULSE[7:0] - 8'h01)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // state register
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state <= ST_IDLE;
        end
        else if (ce_i)
        begin
            state <= next_state;
        end
    end

    // unit and action selection, stored at each taken load
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            unit_min <= 1'b0;
            act_nmi  <= `SWDT_ACT_RESET;
        end
        else if (ce_i && take)
        begin
            unit_min <= unit_min_i;
            act_nmi  <= act_nmi_i;
        end
    end

    // remaining count: a load restarts it, each tick steps it down
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            count_o <= `SWDT_TMO_RST;
        end
        else if (ce_i)
        begin
            if (take)
            begin
                count_o <= tmo_i;
            end
            else if (step)
            begin
                count_o <= count_o - 1'b1;
            end
        end
    end

    // armed while the countdown runs
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            armed_o <= 1'b0;
        end
        else if (ce_i)
        begin
            armed_o <= (next_state == ST_RUN);
        end
    end

    // one-cycle marker on the run-to-fire step
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            expired_o <= 1'b0;
        end
        else if (ce_i)
        begin
            expired_o <= fire_start;
        end
    end

    // cold reset held for the whole fire phase
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cold_rst_o <= 1'b0;
        end
        else if (ce_i)
        begin
            cold_rst_o <= fire_next && (act_nmi == `SWDT_ACT_RESET);
        end
    end

    // nmi only on the first fire cycle
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            nmi_o <= 1'b0;
        end
        else if (ce_i)
        begin
            nmi_o <= fire_start && (act_nmi == `SWDT_ACT_NMI);
        end
    end

    // fire phase length counter
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pulse_cnt <= 8'h00;
        end
        else if (ce_i)
        begin
            if (fire_next && state == ST_FIRE)
            begin
                pulse_cnt <= pulse_cnt + 8'h01;
            end
            else
            begin
                pulse_cnt <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire
